/* include/pesp_pkg.sv */
/*
 Types shared by the port 1 egress shaping and PHY control block.
 Assumes the constants header is on the include path.
*/
package pesp_pkg;
  // Register port request, one cycle per strobe.
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pesp_bus_t;
  // Frame start of one queue: pulse with the frame length in bytes.
  typedef struct packed {
    logic        start;
    logic [10:0] len;
  } pesp_frame_t;
  // Cable test progress.
  typedef enum logic {CBL_IDLE, CBL_RUN} pesp_cbl_t;
endpackage

/* include/pesp_regs.svh */
/*
 Constants of the port 1 egress shaping and PHY control block: offsets, field positions, reset values and counts.
 Assumes inclusion by its bare name from the design module.
*/
// Overview of operation
// - Queue 3 rate code in bits 15:12.
// - Queue 2 rate code in bits 11:8.
// - Queue 1 rate code in bits 7:4.
// - Queue 0 rate code in bits 3:0.
// - Codes map zero unlimited, 64 Kbps..88 Mbps.
// - Shaping delays frames, never discards them.
// - At 10 Mbps, rates above ten unlimited.
// - Single queue mode limits only queue 0.
// - Cable test bit starts test, self clears.
// - Results valid while test bit reads zero.
// - Bits 14:13 report cable test outcome.
// - Bit 15 flags short under ten meters.
// - Bit 11 forces link pass.
// - Bit 10, reset one, disables power saving.
// - Bit 9 loops line back at PHY.
// - Control four bit 15 blanks indicators high.
// - Control four bit 14 disables transmitter.
// - Control four bit 13 restarts auto-negotiation.
// - Alias locations reach the same storage.
// - Gap option adds 12 bytes per frame.
// - Preamble option adds 8 bytes per frame.
`ifndef PESP_REGS_SVH
`define PESP_REGS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PESP_OFS_SPECIAL  8'h00
`define PESP_OFS_CTRL4    8'h02
`define PESP_OFS_CTRL3    8'h06
`define PESP_OFS_EGRESS   8'h0A
`define PESP_OFS_PHY_VCT  8'h20
`define PESP_OFS_PHY_MODE 8'h22
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PESP_SP_SHORT     15
`define PESP_SP_RES_HI    14
`define PESP_SP_RES_LO    13
`define PESP_SP_VCT_EN    12
`define PESP_SP_FORCE     11
`define PESP_SP_PWRSAVE   10
`define PESP_SP_LOOP      9
`define PESP_C4_LED_OFF   15
`define PESP_C4_TX_DIS    14
`define PESP_C4_AN_RST    13
`define PESP_C4_PDOWN     11
`define PESP_C3_IFG       1
`define PESP_C3_PRE       0
`define PESP_PV_VCT_EN    15
`define PESP_PV_RES_HI    14
`define PESP_PV_RES_LO    13
`define PESP_PV_SHORT     12
`define PESP_PM_FORCE     3
`define PESP_PM_PWRSAVE   2
`define PESP_PM_LOOP      1
// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define PESP_RST_PWRSAVE  1'h1
`define PESP_RST_RATE     16'h0000
`define PESP_CLK_KHZ      250000
`define PESP_IFG_BYTES    12
`define PESP_PRE_BYTES    8
`define PESP_TEN_MEG_KBPS 10000
`endif

/* logic/pesp_port_ctrl.sv */
/*
 Port 1 register bank: four-queue egress shaper, cable test control and PHY control bits.
 Assumes all inputs come from logic on clk_in; queues start a frame only while eligible.
*/
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`include "pesp_regs.svh"
module pesp_port_ctrl #(
  parameter int BURST_BYTES = 1536
) (
  // Clock, reset, enable
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      ce_in,
  // Register port
  input  wire pesp_pkg::pesp_bus_t       bus_in,
  output logic [15:0]                    rdata_out,
  // Link conditions
  input  wire logic                      speed_100_in,
  input  wire logic                      multi_queue_en_in,
  // Queues
  input  wire pesp_pkg::pesp_frame_t [3:0] frame_in,
  output logic [3:0]                     eligible_out,
  // Cable test engine
  output logic                           cable_start_out,
  input  wire logic                      cable_done_in,
  input  wire logic [1:0]                cable_result_in,
  input  wire logic                      cable_short_near_in,
  // PHY controls
  output logic                           force_link_out,
  output logic                           pwrsave_dis_out,
  output logic                           remote_loop_out,
  output logic                           tx_disable_out,
  output logic                           an_restart_out,
  output logic                           power_down_out,
  // Indicators
  input  wire logic [3:0]                port1_indicator_in,
  output logic [3:0]                     port1_indicator_out
);
  import pesp_pkg::*;

  localparam int          BYTE_ACC = `PESP_CLK_KHZ * 8;
  localparam logic [20:0] ACC_STEP = 21'(BYTE_ACC);
  localparam logic signed [15:0] BURST = 16'(BURST_BYTES);

  initial
  begin
    if (BURST_BYTES < 64 || BURST_BYTES > 16000)
      $error("BURST_BYTES out of range");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Rate code to Kbps.
  function automatic logic [16:0] rate_kbps(input logic [3:0] code);
    unique case (code)
      4'h0: rate_kbps = 17'h00000;
      4'h1: rate_kbps = 17'd64;
      4'h2: rate_kbps = 17'd128;
      4'h3: rate_kbps = 17'd256;
      4'h4: rate_kbps = 17'd512;
      4'h5: rate_kbps = 17'd1000;
      4'h6: rate_kbps = 17'd2000;
      4'h7: rate_kbps = 17'd4000;
      4'h8: rate_kbps = 17'd8000;
      4'h9: rate_kbps = 17'd16000;
      4'hA: rate_kbps = 17'd32000;
      4'hB: rate_kbps = 17'd48000;
      4'hC: rate_kbps = 17'd64000;
      4'hD: rate_kbps = 17'd72000;
      4'hE: rate_kbps = 17'd80000;
      4'hF: rate_kbps = 17'd88000;
    endcase
  endfunction

  // Write strobe hit on one offset.
  function automatic logic wr_hit(input pesp_bus_t b, input logic [7:0] ofs);
    wr_hit = b.wr && (b.addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic        force_link_reg;
  logic        pwrsave_dis_reg;
  logic        loop_reg;
  logic        led_off_reg;
  logic        tx_dis_reg;
  logic        an_rst_reg;
  logic        pdown_reg;
  logic        ifg_reg;
  logic        pre_reg;
  logic [15:0] rate_reg;
  logic [1:0]  result_reg;
  logic        short_reg;
  pesp_cbl_t   cbl_state_reg;
  logic        wr_sp;
  logic        wr_c4;
  logic        wr_pv;
  logic        wr_pm;
  logic        test_req;

  assign wr_sp = wr_hit(bus_in, `PESP_OFS_SPECIAL);
  assign wr_c4 = wr_hit(bus_in, `PESP_OFS_CTRL4);
  assign wr_pv = wr_hit(bus_in, `PESP_OFS_PHY_VCT);
  assign wr_pm = wr_hit(bus_in, `PESP_OFS_PHY_MODE);
  // A one at either alias starts a test; a zero never aborts one.
  assign test_req = (wr_sp && bus_in.wdata[`PESP_SP_VCT_EN])
                 || (wr_pv && bus_in.wdata[`PESP_PV_VCT_EN]);

  // Special control bits, reachable at the port offset and the PHY alias.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      force_link_reg  <= 1'h0;
      pwrsave_dis_reg <= `PESP_RST_PWRSAVE;
      loop_reg        <= 1'h0;
    end
    else if (ce_in && wr_sp)
    begin
      force_link_reg  <= bus_in.wdata[`PESP_SP_FORCE];
      pwrsave_dis_reg <= bus_in.wdata[`PESP_SP_PWRSAVE];
      loop_reg        <= bus_in.wdata[`PESP_SP_LOOP];
    end
    else if (ce_in && wr_pm)
    begin
      force_link_reg  <= bus_in.wdata[`PESP_PM_FORCE];
      pwrsave_dis_reg <= bus_in.wdata[`PESP_PM_PWRSAVE];
      loop_reg        <= bus_in.wdata[`PESP_PM_LOOP];
    end
  end

  // Control four bits 15:13 and 11; bit 12 and bits 10:0 are not kept here.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      led_off_reg <= 1'h0;
      tx_dis_reg  <= 1'h0;
      an_rst_reg  <= 1'h0;
      pdown_reg   <= 1'h0;
    end
    else if (ce_in && wr_c4)
    begin
      led_off_reg <= bus_in.wdata[`PESP_C4_LED_OFF];
      tx_dis_reg  <= bus_in.wdata[`PESP_C4_TX_DIS];
      an_rst_reg  <= bus_in.wdata[`PESP_C4_AN_RST];
      pdown_reg   <= bus_in.wdata[`PESP_C4_PDOWN];
    end
  end

  // Counting options and the egress rate codes.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ifg_reg  <= 1'h0;
      pre_reg  <= 1'h0;
      rate_reg <= `PESP_RST_RATE;
    end
    else if (ce_in)
    begin
      if (wr_hit(bus_in, `PESP_OFS_CTRL3))
      begin
        ifg_reg <= bus_in.wdata[`PESP_C3_IFG];
        pre_reg <= bus_in.wdata[`PESP_C3_PRE];
      end
      if (wr_hit(bus_in, `PESP_OFS_EGRESS))
        rate_reg <= bus_in.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Cable test
  // ----------------------------------------------------------------
  // A start request in the cycle of completion wins, so it is not lost.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cbl_state_reg   <= CBL_IDLE;
      cable_start_out <= 1'h0;
      result_reg      <= 2'h0;
      short_reg       <= 1'h0;
    end
    else if (ce_in)
    begin
      cable_start_out <= 1'h0;
      unique case (cbl_state_reg)
        CBL_IDLE:
        begin
          if (test_req)
          begin
            cbl_state_reg   <= CBL_RUN;
            cable_start_out <= 1'h1;
          end
        end
        CBL_RUN:
        begin
          if (cable_done_in)
          begin
            result_reg <= cable_result_in;
            short_reg  <= cable_short_near_in;
            if (test_req)
              cable_start_out <= 1'h1;
            else
              cbl_state_reg <= CBL_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Egress shaper
  // ----------------------------------------------------------------
  logic [16:0]        eff_kbps [4];
  logic [3:0]         limited;
  logic [20:0]        acc_reg  [4];
  logic [20:0]        acc_next [4];
  logic signed [15:0] credit_reg  [4];
  logic signed [15:0] credit_next [4];
  logic signed [15:0] overhead;

  // Gap and preamble bytes are charged to every frame when enabled.
  assign overhead = (ifg_reg ? 16'(`PESP_IFG_BYTES) : 16'h0000)
                  + (pre_reg ? 16'(`PESP_PRE_BYTES) : 16'h0000);

  // Effective rate per queue after the speed and queue-mode overrides.
  always_comb
  begin
    for (int q = 0; q < 4; q++)
    begin
      eff_kbps[q] = rate_kbps(rate_reg[q*4 +: 4]);
      if (!speed_100_in && eff_kbps[q] > 17'(`PESP_TEN_MEG_KBPS))
        eff_kbps[q] = 17'h00000;
      if (!multi_queue_en_in && q != 0)
        eff_kbps[q] = 17'h00000;
      limited[q] = (eff_kbps[q] != 17'h00000);
    end
  end

  // Token bucket: credit in bytes, one byte earned per ACC_STEP of rate sum.
  always_comb
  begin
    for (int q = 0; q < 4; q++)
    begin
      acc_next[q]    = acc_reg[q] + 21'(eff_kbps[q]);
      credit_next[q] = credit_reg[q];
      if (acc_next[q] >= ACC_STEP)
      begin
        acc_next[q]    = acc_next[q] - ACC_STEP;
        credit_next[q] = credit_next[q] + 16'h0001;
      end
      if (frame_in[q].start)
        credit_next[q] = credit_next[q] - 16'(frame_in[q].len) - overhead;
      if (credit_next[q] > BURST)
        credit_next[q] = BURST;
      if (!limited[q])
      begin
        acc_next[q]    = 21'h000000;
        credit_next[q] = BURST;
      end
    end
  end

  // Credit state; a debt only delays the queue, frames are never dropped.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int q = 0; q < 4; q++)
      begin
        acc_reg[q]    <= 21'h000000;
        credit_reg[q] <= 16'h0000;
      end
    end
    else if (ce_in)
    begin
      for (int q = 0; q < 4; q++)
      begin
        acc_reg[q]    <= acc_next[q];
        credit_reg[q] <= credit_next[q];
      end
    end
  end

  // Eligibility is combinational so a code of zero releases a queue at once.
  always_comb
  begin
    for (int q = 0; q < 4; q++)
      eligible_out[q] = !limited[q] || (credit_reg[q] >= 16'sh0000);
  end

  // ----------------------------------------------------------------
  // PHY and indicator outputs
  // ----------------------------------------------------------------
  assign force_link_out  = force_link_reg;
  assign pwrsave_dis_out = pwrsave_dis_reg;
  assign remote_loop_out = loop_reg;
  assign tx_disable_out  = tx_dis_reg;
  assign power_down_out  = pdown_reg;

  // Restart pulse per written one; indicators blanked high from a flop.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      an_restart_out      <= 1'h0;
      port1_indicator_out <= 4'hF;
    end
    else if (ce_in)
    begin
      an_restart_out      <= wr_c4 && bus_in.wdata[`PESP_C4_AN_RST];
      port1_indicator_out <= led_off_reg ? 4'hF : port1_indicator_in;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;

  // Unmapped offsets and reserved bits read zero.
  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (bus_in.addr)
      `PESP_OFS_SPECIAL:
      begin
        rd_mux[`PESP_SP_SHORT]                    = short_reg;
        rd_mux[`PESP_SP_RES_HI:`PESP_SP_RES_LO]   = result_reg;
        rd_mux[`PESP_SP_VCT_EN]                   = (cbl_state_reg == CBL_RUN);
        rd_mux[`PESP_SP_FORCE]                    = force_link_reg;
        rd_mux[`PESP_SP_PWRSAVE]                  = pwrsave_dis_reg;
        rd_mux[`PESP_SP_LOOP]                     = loop_reg;
      end
      `PESP_OFS_CTRL4:
      begin
        rd_mux[`PESP_C4_LED_OFF] = led_off_reg;
        rd_mux[`PESP_C4_TX_DIS]  = tx_dis_reg;
        rd_mux[`PESP_C4_AN_RST]  = an_rst_reg;
        rd_mux[`PESP_C4_PDOWN]   = pdown_reg;
      end
      `PESP_OFS_CTRL3:
      begin
        rd_mux[`PESP_C3_IFG] = ifg_reg;
        rd_mux[`PESP_C3_PRE] = pre_reg;
      end
      `PESP_OFS_EGRESS: rd_mux = rate_reg;
      `PESP_OFS_PHY_VCT:
      begin
        rd_mux[`PESP_PV_VCT_EN]                 = (cbl_state_reg == CBL_RUN);
        rd_mux[`PESP_PV_RES_HI:`PESP_PV_RES_LO] = result_reg;
        rd_mux[`PESP_PV_SHORT]                  = short_reg;
      end
      `PESP_OFS_PHY_MODE:
      begin
        rd_mux[`PESP_PM_FORCE]   = force_link_reg;
        rd_mux[`PESP_PM_PWRSAVE] = pwrsave_dis_reg;
        rd_mux[`PESP_PM_LOOP]    = loop_reg;
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 16'h0000;
    else if (ce_in)
      rdata_out <= bus_in.rd ? rd_mux : 16'h0000;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_zero_unlimited;
    (rate_reg[3:0] == 4'h0) |-> eligible_out[0];
  endproperty
  a_zero_unlimited: assert property (p_zero_unlimited) else $error("code zero queue not eligible");

  property p_single_queue;
    !multi_queue_en_in |-> (eligible_out[3:1] == 3'h7);
  endproperty
  a_single_queue: assert property (p_single_queue) else $error("upper queue limited in single mode");

  property p_ten_meg;
    (!speed_100_in && rate_reg[15:12] >= 4'h9) |-> eligible_out[3];
  endproperty
  a_ten_meg: assert property (p_ten_meg) else $error("fast code limited at 10 Mbps");

  property p_debt_holds;
    (limited[0] && credit_reg[0] < 16'sh0000) |-> !eligible_out[0];
  endproperty
  a_debt_holds: assert property (p_debt_holds) else $error("queue released while in debt");

  property p_test_start;
    (ce_in && cbl_state_reg == CBL_IDLE && test_req) |=> (cable_start_out && cbl_state_reg == CBL_RUN);
  endproperty
  a_test_start: assert property (p_test_start) else $error("cable test did not start");

  property p_test_done;
    (ce_in && cbl_state_reg == CBL_RUN && cable_done_in && !test_req)
      |=> (cbl_state_reg == CBL_IDLE && result_reg == $past(cable_result_in)
           && short_reg == $past(cable_short_near_in));
  endproperty
  a_test_done: assert property (p_test_done) else $error("cable result not captured");

  property p_led_blank;
    (ce_in && led_off_reg) |=> (port1_indicator_out == 4'hF);
  endproperty
  a_led_blank: assert property (p_led_blank) else $error("indicators not blanked");

  property p_alias_force;
    (ce_in && wr_pm && !wr_sp) |=> (force_link_out == $past(bus_in.wdata[`PESP_PM_FORCE]));
  endproperty
  a_alias_force: assert property (p_alias_force) else $error("alias write missed force link");

  property p_reserved_zero;
    (ce_in && bus_in.rd && bus_in.addr == `PESP_OFS_SPECIAL) |=> (rdata_out[8:0] == 9'h000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  c_test_done: cover property (cbl_state_reg == CBL_RUN ##1 cbl_state_reg == CBL_IDLE);
  c_an_pulse:  cover property (an_restart_out);
  c_throttled: cover property (limited[0] ##0 !eligible_out[0] ##[1:1000] eligible_out[0]);
  c_alias_vct: cover property (wr_pv && test_req);
endmodule

/* tb/testbench.sv */
/*
 Self-checking bench of the port 1 register bank, cable test and shaper.
 Assumes the package on the include path; the design holds its own assertions.
*/
`timescale 1ns/1ns
module testbench;
  import pesp_pkg::*;
  // ------------------------------
  // Stimulus and observed signals
  // ------------------------------
  logic              clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  pesp_bus_t         bus_in = '0;
  pesp_frame_t [3:0] frame_in = '0;
  logic              speed_100_in = 1'b1;
  logic              multi_queue_en_in = 1'b1;
  logic              ce_in = 1'b1;
  logic              cable_done_in = 1'b0;
  logic [1:0]        cable_result_in = 2'h0;
  logic              cable_short_near_in = 1'b0;
  logic [3:0]        port1_indicator_in = 4'h5;
  logic [15:0]       rdata_out;
  logic [3:0]        eligible_out;
  logic [3:0]        port1_indicator_out;
  logic              cable_start_out, force_link_out, pwrsave_dis_out;
  logic              remote_loop_out, tx_disable_out, an_restart_out, power_down_out;
  int                fails = 0;
  int                total_checks = 0;

  // A shallow bucket keeps refill times short.
  pesp_port_ctrl #(.BURST_BYTES(64)) pesp_port_ctrl_i (
    .clk_in              (clk_in),
    .rst_n_in            (rst_n_in),
    .ce_in               (ce_in),
    .bus_in              (bus_in),
    .rdata_out           (rdata_out),
    .speed_100_in        (speed_100_in),
    .multi_queue_en_in   (multi_queue_en_in),
    .frame_in            (frame_in),
    .eligible_out        (eligible_out),
    .cable_start_out     (cable_start_out),
    .cable_done_in       (cable_done_in),
    .cable_result_in     (cable_result_in),
    .cable_short_near_in (cable_short_near_in),
    .force_link_out      (force_link_out),
    .pwrsave_dis_out     (pwrsave_dis_out),
    .remote_loop_out     (remote_loop_out),
    .tx_disable_out      (tx_disable_out),
    .an_restart_out      (an_restart_out),
    .power_down_out      (power_down_out),
    .port1_indicator_in  (port1_indicator_in),
    .port1_indicator_out (port1_indicator_out)
  );

  // Clock of 4 ns period.
  always #2 clk_in = ~clk_in;

  // ------------------------------
  // Shared tasks
  // ------------------------------
  // Compare and count; unknowns never match.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  // Print counts and verdict, then stop.
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus_in <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus_in <= '0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string m);
    @(posedge clk_in);
    bus_in <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_in);
    bus_in <= '0;
    #1;
    chk(rdata_out, exp, m);
  endtask

  // One frame start on queue q; returns after the charging edge.
  task automatic pulse(input int q, input logic [10:0] len);
    @(posedge clk_in);
    frame_in[q] <= '{1'b1, len};
    @(posedge clk_in);
    frame_in[q] <= '0;
    #1;
  endtask

  // Cycles until queue 0 is eligible again must fall in lo..hi.
  task automatic recover(input int lo, input int hi, input string m);
    int n;
    n = 0;
    while (eligible_out[0] !== 1'b1 && n < 3000)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n == 3000)
    begin
      fails++;
      summarize;
    end
    else
      chk(16'(n >= lo && n <= hi), 16'h0001, m);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  // Defaults after reset.
  task automatic t_reset;
    rd(8'h00, 16'h0400, "sp rst");
    rd(8'h02, 16'h0000, "c4 rst");
    rd(8'h0A, 16'h0000, "eg rst");
    chk(eligible_out, 4'hF, "elig rst");
    chk(port1_indicator_out, 4'h5, "ind rst");
    $display("test reset done");
  endtask

  // PHY control bits, read-only fields and the alias location.
  task automatic t_special;
    wr(8'h00, 16'hEFFF);
    #1;
    chk({force_link_out, pwrsave_dis_out, remote_loop_out}, 3'h7, "phy");
    rd(8'h00, 16'h0E00, "sp ro");
    rd(8'h22, 16'h000E, "alias b");
    wr(8'h22, 16'h0000);
    #1;
    chk({force_link_out, pwrsave_dis_out, remote_loop_out}, 3'h0, "phy0");
    rd(8'h00, 16'h0000, "alias wr");
    wr(8'h00, 16'h0400);
    wr(8'h10, 16'hFFFF);
    rd(8'h10, 16'h0000, "unmap");
    rd(8'h0A, 16'h0000, "unmap wr");
    $display("test special done");
  endtask

  // Control four: blanking, transmitter, restart pulse, power down.
  task automatic t_ctrl4;
    wr(8'h02, 16'hFFFF);
    #1;
    chk({an_restart_out, tx_disable_out, power_down_out}, 3'h7, "c4");
    @(posedge clk_in);
    #1;
    chk(an_restart_out, 1'h0, "an");
    chk(port1_indicator_out, 4'hF, "blank");
    rd(8'h02, 16'hE800, "c4 ro");
    wr(8'h02, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1;
    chk({tx_disable_out, power_down_out, port1_indicator_out}, 6'h05, "c4 0");
    $display("test ctrl4 done");
  endtask

  // A low enable freezes the block, so a write strobe in that time is not taken.
  task automatic t_enable;
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(8'h02, 16'h4000);
    @(posedge clk_in);
    ce_in <= 1'b1;
    #1;
    chk(tx_disable_out, 1'h0, "ce frozen");
    rd(8'h02, 16'h0000, "ce rd");
    $display("test enable done");
  endtask

  // Every result code of the cable test, seen at both locations.
  task automatic t_cable;
    for (int r = 0; r < 4; r++)
    begin
      // The last round starts through the alias; old results stand while running.
      if (r == 3)
        wr(8'h20, 16'h8000);
      else
        wr(8'h00, 16'h1400);
      #1;
      chk(cable_start_out, 1'h1, "start");
      rd(8'h00, {(r == 3), ((r == 0) ? 2'h0 : 2'(r - 1)), 13'h1400}, "run");
      @(posedge clk_in);
      cable_done_in <= 1'b1;
      cable_result_in <= r[1:0];
      cable_short_near_in <= (r == 2);
      @(posedge clk_in);
      cable_done_in <= 1'b0;
      rd(8'h00, {(r == 2), r[1:0], 13'h0400}, "res");
      rd(8'h20, {1'b0, r[1:0], (r == 2), 12'h000}, "alias a");
    end
    $display("test cable done");
  endtask

  // 88 Mbps refill time, then the same with gap and preamble counted.
  task automatic t_shape;
    wr(8'h0A, 16'h1234);
    rd(8'h0A, 16'h1234, "eg rw");
    wr(8'h0A, 16'h000F);
    repeat (2000) @(posedge clk_in);
    pulse(0, 11'h064);
    chk(eligible_out[0], 1'h0, "held");
    recover(36 * 22 - 23, 36 * 23 + 23, "88M");
    wr(8'h06, 16'h0003);
    rd(8'h06, 16'h0003, "c3");
    repeat (2000) @(posedge clk_in);
    pulse(0, 11'h064);
    recover(56 * 22 - 23, 56 * 23 + 23, "ovh");
    $display("test shape done");
  endtask

  // Slow port and single queue overrides.
  task automatic t_modes;
    @(posedge clk_in);
    speed_100_in <= 1'b0;
    pulse(0, 11'h064);
    chk(eligible_out[0], 1'h1, "10M");
    wr(8'h0A, 16'h0008);
    pulse(0, 11'h064);
    chk(eligible_out[0], 1'h0, "10M 8M");
    @(posedge clk_in);
    speed_100_in <= 1'b1;
    multi_queue_en_in <= 1'b0;
    wr(8'h0A, 16'hF000);
    pulse(3, 11'h064);
    chk(eligible_out, 4'hF, "single");
    @(posedge clk_in);
    multi_queue_en_in <= 1'b1;
    pulse(3, 11'h064);
    chk(eligible_out[3], 1'h0, "q3");
    $display("test modes done");
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  // Reset for 16 cycles, then every scenario in turn.
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_special;
    t_ctrl4;
    t_enable;
    t_cable;
    t_shape;
    t_modes;
    summarize;
  end
endmodule
